// file: hdl/mcex_defines.svh
// Purpose: constants for the instruction execute block
// Assumes: 14-bit instruction words, 8-bit data path
// Notes: opcodes are matched with masks
`ifndef MCEX_DEFINES_SVH
`define MCEX_DEFINES_SVH
`define MCEX_PC_W 11
`define MCEX_FADDR_W 7
`define MCEX_STACK_DEPTH 6
`define MCEX_ACC_RST 8'h00
`define MCEX_NOP_WORD 14'h0000
`define MCEX_OP_RET 14'h0040
`define MCEX_OP_IRQ_EXIT 14'h0060
`define MCEX_OP_ACC_CLEAR 14'h0140
`define MCEX_OP_WDT 14'h0089
`define MCEX_DEST_BIT 7
`define MCEX_BIT_LSB 6
`define MCEX_STAT_Z 2
`define MCEX_STAT_DC 1
`define MCEX_STAT_C 0
`endif

// file: hdl/mcex_pkg.sv
// Purpose: types for the instruction execute block
// Assumes: mcex_defines.svh included here
// Notes: decoded operation classes
`include "mcex_defines.svh"
package mcex_pkg;
  typedef logic [13:0] mcex_word_t;
  typedef enum logic [2:0] {
    MCEX_RUN = 3'b001,
    MCEX_FLUSH = 3'b010,
    MCEX_HALT = 3'b100
  } mcex_state_e;
  typedef enum logic [4:0] {
    MCEX_K_NOP, MCEX_K_ACC_AND_FILE, MCEX_K_ACC_OR_FILE, MCEX_K_FILE_INVERT, MCEX_K_FILE_DECREMENT,
    MCEX_K_FILE_INCREMENT, MCEX_K_DECSZ, MCEX_K_INCSZ, MCEX_K_FILE_TO_ACC, MCEX_K_ACC_TO_FILE,
    MCEX_K_FILE_CLEAR, MCEX_K_ACC_CLEAR, MCEX_K_WDT, MCEX_K_BCF, MCEX_K_BSF,
    MCEX_K_BTC, MCEX_K_BTS, MCEX_K_ANDL, MCEX_K_IORL, MCEX_K_MOVL,
    MCEX_K_CALL, MCEX_K_JUMP_ABSOLUTE, MCEX_K_RET, MCEX_K_IRQ_EXIT, MCEX_K_RETL,
    MCEX_K_OTHER
  } mcex_kind_e;
endpackage : mcex_pkg

// file: hdl/mcex_dec_if.sv
// Purpose: carries a decoded instruction between decoder and core
// Assumes: combinational decode
// Notes: word in, kind out
`timescale 1ns/100ps
interface mcex_dec_if;
  import mcex_pkg::*;
  mcex_word_t word;
  mcex_kind_e kind;
  modport dec (input word, output kind);
  modport core (output word, input kind);
endinterface : mcex_dec_if

// file: hdl/mcex_decode.sv
// Purpose: classifies a 14-bit instruction word
// Assumes: undefined words fall to MCEX_K_OTHER
// Notes: purely combinational
`timescale 1ns/100ps
`include "mcex_defines.svh"
module mcex_decode (
  mcex_dec_if.dec dif // decode carrier
);
  import mcex_pkg::*;
  // match fixed opcode fields, most specific first
  always_comb begin
    mcex_word_t w;
    w = dif.word;
    dif.kind = MCEX_K_OTHER;
    if (w == `MCEX_NOP_WORD) dif.kind = MCEX_K_NOP;
    else if (w == `MCEX_OP_RET) dif.kind = MCEX_K_RET;
    else if (w == `MCEX_OP_IRQ_EXIT) dif.kind = MCEX_K_IRQ_EXIT;
    else if (w == `MCEX_OP_ACC_CLEAR) dif.kind = MCEX_K_ACC_CLEAR;
    else if (w == `MCEX_OP_WDT) dif.kind = MCEX_K_WDT;
    else if (w[13:7] == 7'h01) dif.kind = MCEX_K_ACC_TO_FILE;
    else if (w[13:7] == 7'h03) dif.kind = MCEX_K_FILE_CLEAR;
    else if (w[13:7] == 7'h10) dif.kind = MCEX_K_FILE_TO_ACC;
    else if (w[13:12] == 2'h2 && !w[11]) dif.kind = MCEX_K_CALL;
    else if (w[13:12] == 2'h3 && !w[11]) dif.kind = MCEX_K_JUMP_ABSOLUTE;
    else if (w[13:12] == 2'h0) begin
      unique case (w[11:8])
        4'h5: dif.kind = MCEX_K_ACC_AND_FILE;
        4'h4: dif.kind = MCEX_K_ACC_OR_FILE;
        4'h9: dif.kind = MCEX_K_FILE_INVERT;
        4'h3: dif.kind = MCEX_K_FILE_DECREMENT;
        4'ha: dif.kind = MCEX_K_FILE_INCREMENT;
        4'hb: dif.kind = MCEX_K_DECSZ;
        4'hf: dif.kind = MCEX_K_INCSZ;
        default: dif.kind = MCEX_K_OTHER;
      endcase
    end else if (w[13:12] == 2'h1) begin
      unique case (w[11:8])
        4'h0, 4'h1: dif.kind = MCEX_K_BCF;
        4'h2, 4'h3: dif.kind = MCEX_K_BSF;
        4'h4, 4'h5: dif.kind = MCEX_K_BTC;
        4'h6, 4'h7: dif.kind = MCEX_K_BTS;
        4'hb: dif.kind = MCEX_K_ANDL;
        4'ha: dif.kind = MCEX_K_IORL;
        4'h9: dif.kind = MCEX_K_MOVL;
        4'h8: dif.kind = MCEX_K_RETL;
        default: dif.kind = MCEX_K_OTHER;
      endcase
    end
  end
endmodule : mcex_decode

// file: hdl/mcex_core.sv
// Purpose: executes one instruction word per cycle with file access
// Assumes: file read data is combinational from file_raddr
// Notes: branches and taken skips flush the fetched word for one cycle;
//   a full stack drops its oldest entry, an empty one pops zero;
//   carry and digit carry are never written by this block;
//   words outside this group execute as a no-op with pc+1
`timescale 1ns/100ps
`include "mcex_defines.svh"
module mcex_core #(
  parameter int PC_W = `MCEX_PC_W, // program counter width
  parameter int DEPTH = `MCEX_STACK_DEPTH // return stack depth
) (
  input wire logic clk_sys, // core clock
  input wire logic arst_n, // async reset, active low
  input wire mcex_pkg::mcex_word_t instr, // fetched instruction word
  input wire logic instr_valid, // instr holds a new word this cycle
  input wire logic [7:0] file_rdata, // data of file at file_raddr
  output logic [6:0] file_raddr, // file read address
  output logic [6:0] file_waddr_ff, // file write address
  output logic [7:0] file_wdata_ff, // file write data
  output logic file_we_ff, // file write strobe, one cycle
  output logic [PC_W-1:0] pc_ff, // program counter
  output logic [7:0] acc_ff, // accumulator
  output logic [2:0] flags_ff, // nil, digit carry, carry
  output logic gie_ff, // global_irq_enable
  output logic wdt_en_ff, // watchdog enabled
  output logic wdt_clr_ff, // watchdog counter clear, one cycle
  output logic busy_ff // second cycle of a two-cycle instruction
);
  import mcex_pkg::*;

  // stack pointer counts from empty to full
  localparam int SP_W = $clog2(DEPTH + 1);

  typedef struct packed {
    mcex_state_e state;
    logic [PC_W-1:0] pc;
    logic [7:0] acc;
    logic [2:0] flags;
    logic global_irq_enable;
    logic wdt_en;
    logic wdt_clr;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic we;
    logic [SP_W-1:0] sp;
    logic [DEPTH-1:0][PC_W-1:0] stack;
  } mcex_core_s;

  // state register, its next value and the decode carrier
  mcex_core_s cur_ff;
  mcex_core_s nxt_cur;
  mcex_dec_if dif();

  // result goes to accumulator or file by destination bit
  function automatic logic to_file(input mcex_word_t w);
    return w[`MCEX_DEST_BIT];
  endfunction : to_file

  // one-hot mask for the bit number of a bit-oriented word
  function automatic logic [7:0] bit_mask(input mcex_word_t w);
    return 8'h01 << w[`MCEX_BIT_LSB +: 3];
  endfunction : bit_mask

  // bit-oriented file group; its file address is only 6 bits wide
  function automatic logic is_bit_op(input mcex_word_t w);
    return w[13:11] == 3'b010;
  endfunction : is_bit_op

  // word classifier
  mcex_decode u_dec (
    .dif(dif)
  );

  // whole word carries opcode and operand fields
  assign dif.word = instr;
  // bit 6 of a bit-oriented word is a bit-number bit, not address
  assign file_raddr = is_bit_op(instr) ? {1'b0, instr[5:0]} : instr[6:0];

  // execute step
  always_comb begin
    logic [7:0] res;
    logic [2:0] bsel;
    logic wr_res;
    logic set_z;
    logic flush;
    logic [PC_W-1:0] ret_pc;
    nxt_cur = cur_ff;
    res = 8'h00;
    bsel = instr[`MCEX_BIT_LSB +: 3]; // b field, bits 8:6
    wr_res = 1'b0;
    set_z = 1'b0;
    flush = 1'b0;
    ret_pc = cur_ff.stack[0];
    nxt_cur.we = 1'b0;
    nxt_cur.wdt_clr = 1'b0;
    nxt_cur.waddr = instr[6:0];
    unique case (cur_ff.state)
      MCEX_FLUSH: begin
        nxt_cur.state = MCEX_RUN; // discarded word acts as no-op
      end
      MCEX_HALT: begin
        nxt_cur.state = MCEX_HALT;
      end
      MCEX_RUN: begin
        if (instr_valid) begin
          nxt_cur.pc = PC_W'(cur_ff.pc + 1'b1);
          unique case (dif.kind)
            // byte-oriented file operations, routed by d below
            MCEX_K_ACC_AND_FILE: begin
              res = cur_ff.acc & file_rdata;
              wr_res = 1'b1;
              set_z = 1'b1;
            end
            MCEX_K_ACC_OR_FILE: begin
              res = cur_ff.acc | file_rdata;
              wr_res = 1'b1;
              set_z = 1'b1;
            end
            MCEX_K_FILE_INVERT: begin
              res = ~file_rdata;
              wr_res = 1'b1;
              set_z = 1'b1;
            end
            MCEX_K_FILE_DECREMENT: begin
              res = file_rdata - 8'h01;
              wr_res = 1'b1;
              set_z = 1'b1;
            end
            MCEX_K_FILE_INCREMENT: begin
              res = file_rdata + 8'h01; // wraps FFh to 00h
              wr_res = 1'b1;
              set_z = 1'b1;
            end
            MCEX_K_DECSZ: begin
              res = file_rdata - 8'h01; // flags kept
              wr_res = 1'b1;
              flush = (res == 8'h00);
            end
            MCEX_K_INCSZ: begin
              res = file_rdata + 8'h01; // flags kept
              wr_res = 1'b1;
              flush = (res == 8'h00);
            end
            // moves between accumulator and file
            MCEX_K_FILE_TO_ACC: begin
              nxt_cur.acc = file_rdata;
            end
            MCEX_K_ACC_TO_FILE: begin
              nxt_cur.wdata = cur_ff.acc;
              nxt_cur.we = 1'b1;
            end
            // file and accumulator clears write zero and set the nil flag
            MCEX_K_FILE_CLEAR: begin
              nxt_cur.wdata = 8'h00;
              nxt_cur.we = 1'b1;
              nxt_cur.flags[`MCEX_STAT_Z] = 1'b1;
            end
            MCEX_K_ACC_CLEAR: begin
              nxt_cur.acc = 8'h00;
              nxt_cur.flags[`MCEX_STAT_Z] = 1'b1;
            end
            MCEX_K_WDT: begin
              nxt_cur.wdt_en = 1'b1;
              nxt_cur.wdt_clr = 1'b1;
            end
            // bit-oriented file operations, flags kept
            MCEX_K_BCF: begin
              nxt_cur.waddr = {1'b0, instr[5:0]}; // 6-bit address
              nxt_cur.wdata = file_rdata & ~bit_mask(instr);
              nxt_cur.we = 1'b1;
            end
            MCEX_K_BSF: begin
              nxt_cur.waddr = {1'b0, instr[5:0]};
              nxt_cur.wdata = file_rdata | bit_mask(instr);
              nxt_cur.we = 1'b1;
            end
            MCEX_K_BTC: begin
              flush = !file_rdata[bsel];
            end
            MCEX_K_BTS: begin
              flush = file_rdata[bsel];
            end
            // literal operations on the accumulator
            MCEX_K_ANDL: begin
              nxt_cur.acc = cur_ff.acc & instr[7:0];
              nxt_cur.flags[`MCEX_STAT_Z] = (nxt_cur.acc == 8'h00);
            end
            MCEX_K_IORL: begin
              nxt_cur.acc = cur_ff.acc | instr[7:0];
              nxt_cur.flags[`MCEX_STAT_Z] = (nxt_cur.acc == 8'h00);
            end
            MCEX_K_MOVL: begin
              nxt_cur.acc = instr[7:0]; // flags kept
            end
            MCEX_K_CALL: begin
              // push return address, then jump
              for (int i = DEPTH - 1; i > 0; i--) begin
                nxt_cur.stack[i] = cur_ff.stack[i-1];
              end
              nxt_cur.stack[0] = PC_W'(cur_ff.pc + 1'b1);
              // a full stack drops its oldest entry at the far end
              if (cur_ff.sp != SP_W'(DEPTH)) begin
                nxt_cur.sp = SP_W'(cur_ff.sp + 1'b1);
              end
              nxt_cur.pc = PC_W'(instr[10:0]);
              flush = 1'b1;
            end
            MCEX_K_JUMP_ABSOLUTE: begin
              nxt_cur.pc = PC_W'(instr[10:0]); // stack untouched
              flush = 1'b1;
            end
            MCEX_K_RET, MCEX_K_IRQ_EXIT, MCEX_K_RETL: begin
              // pop stack_top into pc
              for (int i = 0; i < DEPTH - 1; i++) begin
                nxt_cur.stack[i] = cur_ff.stack[i+1];
              end
              // an empty stack yields zero on a pop
              nxt_cur.stack[DEPTH-1] = '0;
              if (cur_ff.sp != '0) begin
                nxt_cur.sp = SP_W'(cur_ff.sp - 1'b1);
              end
              nxt_cur.pc = ret_pc;
              flush = 1'b1;
              if (dif.kind == MCEX_K_IRQ_EXIT) begin
                nxt_cur.global_irq_enable = 1'b1;
              end
              if (dif.kind == MCEX_K_RETL) begin
                nxt_cur.acc = instr[7:0];
              end
            end
            default: begin
              // no-op and words outside this decoder change only pc, which steps by one
            end
          endcase
          // route result by destination bit
          if (wr_res) begin
            if (to_file(instr)) begin
              nxt_cur.wdata = res;
              nxt_cur.we = 1'b1;
            end else begin
              nxt_cur.acc = res;
            end
          end
          if (set_z) begin
            nxt_cur.flags[`MCEX_STAT_Z] = (res == 8'h00);
          end
          if (flush) begin
            nxt_cur.state = MCEX_FLUSH;
          end
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '{state: MCEX_RUN, acc: `MCEX_ACC_RST, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs are fields of the state register
  assign file_waddr_ff = cur_ff.waddr;
  assign file_wdata_ff = cur_ff.wdata;
  assign file_we_ff = cur_ff.we;
  assign pc_ff = cur_ff.pc;
  assign acc_ff = cur_ff.acc;
  assign flags_ff = cur_ff.flags;
  assign gie_ff = cur_ff.global_irq_enable;
  assign wdt_en_ff = cur_ff.wdt_en;
  assign wdt_clr_ff = cur_ff.wdt_clr;
  assign busy_ff = (cur_ff.state == MCEX_FLUSH);
endmodule : mcex_core

// file: verification/mcex_core_properties.sv
// Purpose: temporal checks on the execute block ports
// Assumes: one clock, async active-low reset
// Notes: bound into every mcex_core instance
`timescale 1ns/100ps
module mcex_core_properties #(
  parameter int PC_W = 11, // program counter width
  parameter int DEPTH = 6 // return stack depth
) (
  input wire logic clk_sys, // core clock
  input wire logic arst_n, // async reset, active low
  input wire mcex_pkg::mcex_word_t instr, // presented word
  input wire logic instr_valid, // word valid
  input wire logic [7:0] file_rdata, // file read data
  input wire logic [6:0] file_raddr, // file read address
  input wire logic [6:0] file_waddr_ff, // file write address
  input wire logic [7:0] file_wdata_ff, // file write data
  input wire logic file_we_ff, // file write strobe
  input wire logic [PC_W-1:0] pc_ff, // program counter
  input wire logic [7:0] acc_ff, // accumulator
  input wire logic [2:0] flags_ff, // nil, digit carry, carry
  input wire logic gie_ff, // global_irq_enable
  input wire logic wdt_en_ff, // watchdog enabled
  input wire logic wdt_clr_ff, // watchdog clear pulse
  input wire logic busy_ff // flush cycle
);
  import mcex_pkg::*;
  logic tk;
  // a word is taken only when valid outside a flush cycle
  assign tk = instr_valid && !busy_ff;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_busy_one;
    busy_ff |=> !busy_ff;
  endproperty
  a_busy_one: assert property (p_busy_one)
    else $error("busy too long");
  property p_flush_nop;
    busy_ff |=> !file_we_ff && $stable(acc_ff) && $stable(flags_ff);
  endproperty
  a_flush_nop: assert property (p_flush_nop)
    else $error("flush acted");
  property p_keep_carry;
    flags_ff[1:0] == 2'h0;
  endproperty
  a_keep_carry: assert property (p_keep_carry)
    else $error("carry moved");
  property p_jump;
    tk && instr[13:11] == 3'h6 |=> busy_ff && pc_ff == $past(instr[10:0]);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target wrong");
  property p_call;
    tk && instr[13:11] == 3'h4 |=> busy_ff && pc_ff == $past(instr[10:0]);
  endproperty
  a_call: assert property (p_call)
    else $error("call target wrong");
  property p_acc_clear;
    tk && instr == 14'h0140 |=> acc_ff == 8'h00 && flags_ff[2];
  endproperty
  a_acc_clear: assert property (p_acc_clear)
    else $error("clear wrong");
  property p_dog_kick;
    tk && instr == 14'h0089 |=> wdt_en_ff && wdt_clr_ff && $stable(flags_ff);
  endproperty
  a_dog_kick: assert property (p_dog_kick)
    else $error("kick wrong");
  property p_irq_exit;
    tk && instr == 14'h0060 |=> gie_ff && busy_ff;
  endproperty
  a_irq_exit: assert property (p_irq_exit)
    else $error("irq exit");
  property p_lit_load;
    tk && instr[13:8] == 6'h19 |=> acc_ff == $past(instr[7:0]) && !busy_ff;
  endproperty
  a_lit_load: assert property (p_lit_load)
    else $error("literal");
  property p_bit_addr;
    instr[13:11] == 3'h2 |-> file_raddr == {1'b0, instr[5:0]};
  endproperty
  a_bit_addr: assert property (p_bit_addr)
    else $error("bit address wrong");
  property p_sub_exit;
    tk && instr == 14'h0040 |=> busy_ff && $stable(acc_ff)
      && $stable(flags_ff);
  endproperty
  a_sub_exit: assert property (p_sub_exit)
    else $error("sub exit changed state");
  // main scenarios reached
  c_call: cover property (tk && instr[13:11] == 3'h4);
  c_skip: cover property (tk && instr[13:10] == 4'h5 ##1 busy_ff);
  c_exit: cover property (tk && instr == 14'h0060);
endmodule : mcex_core_properties
bind mcex_core mcex_core_properties #(.PC_W(PC_W), .DEPTH(DEPTH))
  i_mcex_core_properties (.clk_sys(clk_sys), .arst_n(arst_n),
  .instr(instr), .instr_valid(instr_valid), .file_rdata(file_rdata),
  .file_raddr(file_raddr), .file_waddr_ff(file_waddr_ff),
  .file_wdata_ff(file_wdata_ff), .file_we_ff(file_we_ff), .pc_ff(pc_ff),
  .acc_ff(acc_ff), .flags_ff(flags_ff), .gie_ff(gie_ff),
  .wdt_en_ff(wdt_en_ff), .wdt_clr_ff(wdt_clr_ff), .busy_ff(busy_ff));

// file: verification/tb_top.sv
// Purpose: random self-checking run of the execute block
// Assumes: file memory lives here and is read combinationally
// Notes: a file write is followed by an idle slot so reads see it
`timescale 1ns/100ps
module tb_top;
  import mcex_pkg::*;
  localparam logic [13:0] OPS [24] = '{14'h0500, 14'h0400, 14'h0900,
    14'h0300, 14'h0a00, 14'h0b00, 14'h0f00, 14'h0800, 14'h0080, 14'h0180,
    14'h0140, 14'h0089, 14'h0040, 14'h0060, 14'h1000, 14'h1200, 14'h1400,
    14'h1600, 14'h1b00, 14'h1a00, 14'h1900, 14'h1800, 14'h2000, 14'h3000};
  logic clk_sys, arst_n, instr_valid, file_we_ff, gie_ff, busy_ff;
  logic wdt_en_ff, wdt_clr_ff;
  mcex_word_t instr;
  logic [7:0] file_rdata, file_wdata_ff, acc_ff, e_acc, e_wd;
  logic [6:0] file_raddr, file_waddr_ff, e_wa;
  logic [10:0] pc_ff, e_pc;
  logic [2:0] flags_ff;
  logic [7:0] fm [128];
  logic [41:0] q [$];
  logic [10:0] stk [$];
  logic e_z, e_gie, e_wen, e_clr, e_busy, e_we, idle_nx;
  logic [41:0] act;
  logic [41:0] n;
  int failures, checks, cyc;
  mcex_core i_mcex_core (.clk_sys(clk_sys), .arst_n(arst_n),
    .instr(instr), .instr_valid(instr_valid), .file_rdata(file_rdata),
    .file_raddr(file_raddr), .file_waddr_ff(file_waddr_ff),
    .file_wdata_ff(file_wdata_ff), .file_we_ff(file_we_ff), .pc_ff(pc_ff),
    .acc_ff(acc_ff), .flags_ff(flags_ff), .gie_ff(gie_ff),
    .wdt_en_ff(wdt_en_ff), .wdt_clr_ff(wdt_clr_ff), .busy_ff(busy_ff));
  // file memory: combinational read, write on the strobe
  assign file_rdata = fm[file_raddr];
  always @(posedge clk_sys) begin
    if (file_we_ff === 1'b1) fm[file_waddr_ff] <= file_wdata_ff;
  end
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [13:0] msk(int k);
    if (k < 7 || (k > 17 && k < 22)) return 14'h00ff;
    if (k < 10) return 14'h007f;
    if (k < 14) return 14'h0000;
    if (k < 18) return 14'h01ff;
    return 14'h07ff;
  endfunction : msk
  // return stack pop, empty gives zero
  function automatic logic [10:0] pop_ret();
    return (stk.size() > 0) ? stk.pop_back() : 11'h0;
  endfunction : pop_ret
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // drive one random word and note the expected state after it
  task automatic step();
    logic [13:0] w;
    logic [7:0] fv, r;
    logic [6:0] fa;
    logic zu, dd, wf, sk;
    int k;
    @(negedge clk_sys);
    k = $urandom_range(23);
    w = OPS[k] | (14'($urandom) & msk(k));
    if (w == 14'h008a) w = 14'h0089;
    instr = w;
    instr_valid = !idle_nx && ($urandom_range(7) != 0);
    {zu, dd, wf, sk, r, e_we, e_clr, idle_nx} = '0;
    fa = (w[13:12] == 2'h1) ? {1'b0, w[5:0]} : w[6:0];
    fv = fm[fa];
    if (e_busy) e_busy = 1'b0;
    else if (instr_valid) begin
      e_pc = e_pc + 11'h1;
      casez (w[13:8])
        6'h05: begin r = e_acc & fv; zu = 1; dd = 1; end
        6'h04: begin r = e_acc | fv; zu = 1; dd = 1; end
        6'h09: begin r = ~fv; zu = 1; dd = 1; end
        6'h03: begin r = fv - 8'h1; zu = 1; dd = 1; end
        6'h0a: begin r = fv + 8'h1; zu = 1; dd = 1; end
        6'h0b: begin r = fv - 8'h1; dd = 1; sk = (r == 8'h0); end
        6'h0f: begin r = fv + 8'h1; dd = 1; sk = (r == 8'h0); end
        6'h08: e_acc = fv;
        6'h01: begin zu = 1; dd = 1; end
        6'h00: begin
          if (w == 14'h0089) begin
            e_wen = 1'b1;
            e_clr = 1'b1;
          end else if (w[7]) begin
            r = e_acc;
            dd = 1'b1;
          end else begin
            e_pc = pop_ret();
            e_busy = 1'b1;
            e_gie |= w[5];
          end
        end
        6'h1?: begin
          if (w[11:10] == 2'h1) begin
            sk = (fv[w[8:6]] == w[9]);
          end else if (!w[11]) begin
            r = fv;
            r[w[8:6]] = w[9];
            wf = 1'b1;
          end else if (w[9:8] == 2'h0) begin
            e_acc = w[7:0];
            e_pc = pop_ret();
            e_busy = 1'b1;
          end else if (w[9:8] == 2'h1) begin
            e_acc = w[7:0];
          end else begin
            r = w[8] ? e_acc & w[7:0] : e_acc | w[7:0];
            zu = 1'b1;
            e_acc = r;
          end
        end
        6'h2?: begin
          stk.push_back(e_pc);
          e_pc = w[10:0];
          e_busy = 1'b1;
        end
        default: begin e_pc = w[10:0]; e_busy = 1; end
      endcase
      if (stk.size() > 6) void'(stk.pop_front());
      if (zu) e_z = (r == 8'h00);
      if (dd && !w[7]) e_acc = r;
      else if (dd || wf) {e_we, e_wa, e_wd} = {1'b1, fa, r};
      e_busy = e_busy | sk;
      idle_nx = e_we && !e_busy;
    end
    q.push_back({e_pc, e_acc, e_z, 2'h0, e_gie, e_wen, e_clr, e_busy,
      e_we, e_we ? {e_wa, e_wd} : 15'h0});
  endtask : step
  // watcher: compare the oldest note once outputs settle
  always @(posedge clk_sys) begin
    #1;
    act = {pc_ff, acc_ff, flags_ff, gie_ff, wdt_en_ff, wdt_clr_ff, busy_ff,
      file_we_ff, (file_we_ff === 1'b1) ?
      {file_waddr_ff, file_wdata_ff} : 15'h0};
    if (q.size() > 0) begin
      n = q.pop_front();
      checks++;
      if (act !== n) begin
        failures++;
        $display("[ERR] %0t exp %h got %h", $time, n, act);
      end
    end
  end
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  // reset, preload the file with boundary values, then run
  initial begin
    arst_n = 1'b0;
    instr = 14'h0000;
    instr_valid = 1'b0;
    {e_pc, e_acc, e_wd, e_wa, e_z, e_gie, e_wen, e_clr, e_busy, e_we} = '0;
    idle_nx = 1'b0;
    void'($urandom(32'h017e));
    for (int i = 0; i < 128; i++) begin
      fm[i] = (i % 4 == 3) ? 8'($urandom) : 8'(i % 4 == 2 ? 255 : i % 4);
    end
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4000) step();
    @(negedge clk_sys);
    instr_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    tally_and_finish();
  end
endmodule : tb_top
